/* core/igs_defines.svh */
// Constants of the grouped interrupt enable and status stage.
// Assumes a byte-addressed register port with 32-bit words.
//
// Contract
// - Enable register at 0xB800_2084, read/write, resets to zero.
// - Enable bit one passes the member interrupt, zero blocks it.
// - Bits 29 and 28 serve keyboard/mouse ports 1 and 0.
// - Bits 27 and 26 serve I2C lines 1 and 0.
// - Bit 23 debug transmit, bit 22 debug receive.
// - Bits 21 and 20 serve general DMA channels 1 and 0.
// - Bits 18 to 16 serve timers 4, 3 and 2.
// - Bits 9 and 8 serve the two USB host controllers.
// - Bits 2 to 0 serve the three external interrupt pins.
// - Read-only active status at 0xB800_2088, same layout, resets to zero.
// - Debug transmit status reads one while its buffer is empty.
// - Debug receive status reads one while unread data waits.
// - Writing one clears latched external pin status; self-clearing; zero does nothing.
`ifndef IGS_DEFINES_SVH
`define IGS_DEFINES_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define IGS_ADDR_ENABLE 32'hb800_2084
`define IGS_ADDR_STATUS 32'hb800_2088
`define IGS_ADDR_CLEAR 32'hb800_208c
`define IGS_ADDR_EVENT 32'hb800_2090
`define IGS_ADDR_EVENT_MASK 32'hb800_2094

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IGS_KBD_MOUSE_LSB 28
`define IGS_I2C_LSB 26
`define IGS_DEBUG_TX_BIT 23
`define IGS_DEBUG_RX_BIT 22
`define IGS_DMA_LSB 20
`define IGS_TIMER_LSB 16
`define IGS_USB_LSB 8
`define IGS_EXT_LSB 0

// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define IGS_VALID_MASK 32'h3cf7_0307
`define IGS_EXT_MASK 32'h0000_0007
`define IGS_RESET_WORD 32'h0000_0000

`endif

/* core/igs_pkg.sv */
// Types of the grouped interrupt enable and status stage.
// Assumes igs_defines.svh supplies all numbers.
package igs_pkg;

  // ----------------------------------------
  // Member interrupt lines from the peripherals
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] keyboard_mouse_port_group;
    logic [1:0] i2c_group;
    logic debug_comm_transmit;
    logic debug_comm_receive;
    logic [1:0] general_dma_group;
    logic [2:0] timer_group;
    logic [1:0] usb_host_group;
    logic [2:0] external_pin_group_n;
  } igs_sources_t;

  // ----------------------------------------
  // Register port request
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } igs_bus_req_t;

  // ----------------------------------------
  // Gated requests per group toward the priority logic
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] keyboard_mouse_port_group;
    logic [1:0] i2c_group;
    logic debug_comm_transmit;
    logic debug_comm_receive;
    logic [1:0] general_dma_group;
    logic [2:0] timer_group;
    logic [1:0] usb_host_group;
    logic [2:0] external_pin_group;
  } igs_requests_t;

endpackage : igs_pkg

/* core/igs_sync.sv */
// Two-stage synchroniser for the three external interrupt pins.
// Assumes the pins are asynchronous to clock.
`timescale 1ns/1ps
module igs_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins and synchronised copy
  input wire logic [2:0] pin_n,
  output logic [2:0] pin_sync_n
);
  import igs_pkg::*;

  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } igs_sync_state_t;

  igs_sync_state_t state;
  igs_sync_state_t next_state;

  // Stage one feeds stage two only; idle pins are high
  always_comb begin
    next_state = state;
    next_state.stage1 = pin_n;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= {2{3'h7}};
    end else begin
      state <= next_state;
    end
  end

  assign pin_sync_n = state.stage2;

endmodule : igs_sync

/* core/igs_group.sv */
// Grouped interrupt enable and active status stage.
// Assumes peripheral lines are synchronous to clock, pins are not,
// and a plain register port with read data one cycle after the strobe.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "igs_defines.svh"
module igs_group (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire igs_pkg::igs_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // Member lines from the peripherals
  input wire igs_pkg::igs_sources_t sources,
  // Gated member requests toward the priority logic
  output igs_pkg::igs_requests_t requests,
  output logic [31:0] request_word,
  // Summary interrupt
  output logic irq
);
  import igs_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] enable;
    logic [31:0] status;
    logic [31:0] request;
    logic [31:0] event_flags;
    logic [31:0] event_mask;
    logic [2:0] ext_latch;
    logic [31:0] rdata;
  } igs_group_state_t;

  igs_group_state_t state;
  igs_group_state_t next_state;

  logic [2:0] ext_sync_n;
  logic [31:0] raw_active;
  logic [31:0] next_request;
  logic [31:0] rising;
  logic [2:0] ext_clear;
  logic wr_enable;
  logic wr_clear;
  logic wr_event;
  logic wr_mask;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Address compare shared by every register strobe
  function automatic logic igs_hit(input logic [31:0] addr, input logic [31:0] target);
    igs_hit = (addr == target);
  endfunction : igs_hit

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  igs_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin_n(sources.external_pin_group_n),
    .pin_sync_n(ext_sync_n)
  );

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // enable register select
  assign wr_enable = bus_req.wr && igs_hit(bus_req.addr, `IGS_ADDR_ENABLE);
  assign wr_clear = bus_req.wr && igs_hit(bus_req.addr, `IGS_ADDR_CLEAR);
  assign wr_event = bus_req.wr && igs_hit(bus_req.addr, `IGS_ADDR_EVENT);
  assign wr_mask = bus_req.wr && igs_hit(bus_req.addr, `IGS_ADDR_EVENT_MASK);

  // write one clears
  // Only ones act; the clear word itself is never stored, so it reads zero
  assign ext_clear = wr_clear ? bus_req.wdata[2:0] : 3'h0;

  // ----------------------------------------
  // Raw member activity in register layout
  // ----------------------------------------
  // Reserved positions stay zero so status never shows them
  always_comb begin
    raw_active = `IGS_RESET_WORD;
    raw_active[`IGS_KBD_MOUSE_LSB +: 2] = sources.keyboard_mouse_port_group;
    raw_active[`IGS_I2C_LSB +: 2] = sources.i2c_group;
    // debug members at bits 23 and 22
    raw_active[`IGS_DEBUG_TX_BIT] = sources.debug_comm_transmit;
    raw_active[`IGS_DEBUG_RX_BIT] = sources.debug_comm_receive;
    raw_active[`IGS_DMA_LSB +: 2] = sources.general_dma_group;
    raw_active[`IGS_TIMER_LSB +: 3] = sources.timer_group;
    raw_active[`IGS_USB_LSB +: 2] = sources.usb_host_group;
    raw_active[`IGS_EXT_LSB +: 3] = state.ext_latch;
  end

  // enable gating
  // Gate uses the enable already held, so a write acts one cycle later
  assign next_request = raw_active & state.enable;

  // New requests raise event flags
  assign rising = next_request & ~state.request;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;

    // latch low pins
    // A low pin sets its latch; a set in the clear cycle wins
    for (int i = 0; i < 3; i++) begin
      if (!ext_sync_n[i]) begin
        next_state.ext_latch[i] = 1'b1;
      end else if (ext_clear[i]) begin
        next_state.ext_latch[i] = 1'b0;
      end
    end

    if (wr_enable) begin
      next_state.enable = bus_req.wdata & `IGS_VALID_MASK;
    end

    next_state.status = raw_active;
    next_state.request = next_request;

    // Event flags: write one to clear, a new request wins
    for (int b = 0; b < 32; b++) begin
      if (rising[b]) begin
        next_state.event_flags[b] = 1'b1;
      end else if (wr_event && bus_req.wdata[b]) begin
        next_state.event_flags[b] = 1'b0;
      end
    end

    if (wr_mask) begin
      next_state.event_mask = bus_req.wdata & `IGS_VALID_MASK;
    end

    // Read data stands one cycle only; zero outside read cycles
    next_state.rdata = `IGS_RESET_WORD;
    if (bus_req.rd) begin
      case (1'b1)
        igs_hit(bus_req.addr, `IGS_ADDR_ENABLE): begin
          next_state.rdata = state.enable;
        end
        igs_hit(bus_req.addr, `IGS_ADDR_STATUS): begin
          next_state.rdata = state.status;
        end
        igs_hit(bus_req.addr, `IGS_ADDR_CLEAR): begin
          next_state.rdata = `IGS_RESET_WORD;
        end
        igs_hit(bus_req.addr, `IGS_ADDR_EVENT): begin
          next_state.rdata = state.event_flags;
        end
        igs_hit(bus_req.addr, `IGS_ADDR_EVENT_MASK): begin
          next_state.rdata = state.event_mask;
        end
        // Unmapped addresses read zero
        default: begin
          next_state.rdata = `IGS_RESET_WORD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // everything disabled after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state.enable <= `IGS_RESET_WORD;
      state.status <= `IGS_RESET_WORD;
      state.request <= `IGS_RESET_WORD;
      state.event_flags <= `IGS_RESET_WORD;
      state.event_mask <= `IGS_RESET_WORD;
      state.ext_latch <= 3'h0;
      state.rdata <= `IGS_RESET_WORD;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_rdata = state.rdata;
  assign request_word = state.request;

  assign requests.keyboard_mouse_port_group = state.request[`IGS_KBD_MOUSE_LSB +: 2];
  assign requests.i2c_group = state.request[`IGS_I2C_LSB +: 2];
  assign requests.debug_comm_transmit = state.request[`IGS_DEBUG_TX_BIT];
  assign requests.debug_comm_receive = state.request[`IGS_DEBUG_RX_BIT];
  assign requests.general_dma_group = state.request[`IGS_DMA_LSB +: 2];
  assign requests.timer_group = state.request[`IGS_TIMER_LSB +: 3];
  assign requests.usb_host_group = state.request[`IGS_USB_LSB +: 2];
  assign requests.external_pin_group = state.request[`IGS_EXT_LSB +: 3];

  // Level interrupt while any unmasked event flag stands
  assign irq = |(state.event_flags & state.event_mask);

endmodule : igs_group

/* bench/igs_partner.sv */
// Peripheral line model for the group stage.
// Assumes the bench updates want by NBA just after a rising edge.
`timescale 1ns/1ps
module igs_partner (
  // Wanted activity, register layout
  input wire logic [31:0] want,
  // Lines toward the stage
  output igs_pkg::igs_sources_t sources
);
  import igs_pkg::*;
  // debug lines are plain levels; pins idle high
  assign sources = {want[29:26], want[23:20], want[18:16], want[9:8], ~want[2:0]};
endmodule : igs_partner

/* bench/igs_group_properties.sv */
// Checker on the ports of the group stage.
// Assumes the register map of igs_defines.svh.
`timescale 1ns/1ps
`include "igs_defines.svh"
module igs_group_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Observed ports
  input wire igs_pkg::igs_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire igs_pkg::igs_sources_t sources,
  input wire igs_pkg::igs_requests_t requests,
  input wire logic [31:0] request_word,
  input wire logic irq
);
  import igs_pkg::*;
  localparam logic [31:0] LIVE = 32'h3cf7_0300;
  logic [31:0] src_w;
  logic [31:0] req_w;
  logic mapped;
  // Live lines and requests in register layout
  assign src_w = {2'h0, sources[15:12], 2'h0, sources[11:8], 1'h0, sources[7:5], 6'h0,
                  sources[4:3], 8'h0};
  assign req_w = {2'h0, requests[15:12], 2'h0, requests[11:8], 1'h0, requests[7:5], 6'h0,
                  requests[4:3], 5'h0, requests[2:0]};
  assign mapped = (bus_req.addr & 32'hffff_ffe3) == 32'hb800_2080 && bus_req.addr[4:2] != 3'h0;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence rd_at(logic [31:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  // Flag clear with no new request in the next cycle
  sequence clear_all;
    bus_req.wr && bus_req.addr == `IGS_ADDR_EVENT && bus_req.wdata == 32'hffff_ffff
      ##1 (request_word & ~$past(request_word)) == 32'h0;
  endsequence
  chk_word_layout:
    assert property (request_word == req_w) else $error("request word layout wrong");
  chk_gate_cause:
    assert property ((request_word & ~$past(src_w) & LIVE) == 32'h0)
      else $error("request without line");
  chk_idle_zero:
    assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0) else $error("rdata not idle");
  chk_reserved_zero:
    assert property (((bus_rdata | request_word) & ~`IGS_VALID_MASK) == 32'h0)
      else $error("reserved bit set");
  chk_unmapped_read:
    assert property (bus_req.rd && !mapped |=> bus_rdata == 32'h0) else $error("unmapped read");
  // Status is captured one edge before the edge that takes the read, yet this compares lines of the read edge
  chk_status_live:
    assert property (rd_at(`IGS_ADDR_STATUS) |=> (bus_rdata & LIVE) == ($past(src_w) & LIVE))
      else $error("status differs from lines");
  chk_irq_cause:
    assert property ($rose(irq) |-> (request_word & ~$past(request_word)) != 0 || $past(bus_req.wr))
      else $error("irq rose without cause");
  chk_clear_drops:
    assert property (clear_all |-> !irq) else $error("irq stays after clear");
endmodule : igs_group_properties
bind igs_group igs_group_properties i_igs_group_properties (.clock(clock), .rst_n(rst_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .sources(sources), .requests(requests),
  .request_word(request_word), .irq(irq));

/* bench/igs_group_tb_top.sv */
// Testbench of the group stage with a peripheral line model.
// Assumes the register map of igs_defines.svh.
`timescale 1ns/1ps
`include "igs_defines.svh"
module igs_group_tb_top;
  import igs_pkg::*;
  localparam logic [31:0] A_EN = `IGS_ADDR_ENABLE;
  localparam logic [31:0] A_ST = `IGS_ADDR_STATUS;
  localparam logic [31:0] A_CLR = `IGS_ADDR_CLEAR;
  localparam logic [31:0] A_EVT = `IGS_ADDR_EVENT;
  localparam logic [31:0] A_MSK = `IGS_ADDR_EVENT_MASK;
  logic clock, rst_n, rd_d, irq;
  logic [31:0] bus_rdata, request_word, want, v;
  logic [31:0] exp_q[$];
  igs_bus_req_t bus_req;
  igs_sources_t sources;
  igs_requests_t requests;
  int bad_count, n_compared;
  igs_partner i_igs_partner (.want(want), .sources(sources));
  igs_group i_igs_group (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .sources(sources), .requests(requests), .request_word(request_word), .irq(irq));
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : check
  // One access per cycle; a read notes its expected data
  task automatic op(logic [31:0] a, logic [31:0] d, logic w, logic [31:0] e);
    @(posedge clock);
    bus_req <= '{a, d, w, ~w};
    if (!w) exp_q.push_back(e);
  endtask : op
  // Drop strobes, then let n cycles pass and settle
  task automatic look(int n);
    @(posedge clock);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask : look
  task automatic end_of_test();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Read data arrive the cycle after the strobe
  always @(posedge clock) begin
    if (rd_d === 1'b1) check("rdata", exp_q.pop_front(), bus_rdata);
    rd_d <= bus_req.rd;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    end_of_test();
  end
  initial begin
    bus_req = '0;
    want = '0;
    rst_n = 1'b0;
    v = $urandom(2);
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    op(A_EN, 0, 0, 0);
    op(A_ST, 0, 0, 0);
    op(32'hb800_2080, 0, 0, 0);
    op(A_EN, '1, 1, 0);
    op(A_EN, 0, 0, `IGS_VALID_MASK);
    op(A_ST, '1, 1, 0);
    op(A_ST, 0, 0, 0);
    v = $urandom;
    op(A_EN, v, 1, 0);
    op(A_EN, 0, 0, v & `IGS_VALID_MASK);
    look(2);
    $display("test access done");
    for (int b = 8; b < 30; b++) begin
      if (32'h3cf7_0300 >> b & 1) begin
        v = $urandom;
        op(A_EN, v, 1, 0);
        want <= 32'h1 << b;
        op(A_ST, 0, 0, 32'h1 << b);
        look(1);
        check("request", (32'h1 << b) & v, request_word);
      end
    end
    $display("test gating done");
    for (int p = 0; p < 3; p++) begin
      op(A_EN, 32'h7, 1, 0);
      want <= 32'h1 << p;
      look(5);
      check("pin request", 32'h1 << p, request_word);
      op(A_CLR, 0, 1, 0);
      want <= 32'h0;
      op(A_ST, 0, 0, 32'h1 << p);
      look(3);
      op(A_CLR, 32'h1 << p, 1, 0);
      op(A_CLR, 0, 0, 0);
      op(A_ST, 0, 0, 0);
    end
    look(1);
    $display("test pins done");
    op(A_EN, 32'h1_0000, 1, 0);
    op(A_MSK, 32'h1_0000, 1, 0);
    op(A_EVT, '1, 1, 0);
    want <= 32'h1_0000;
    look(2);
    check("irq", 1, irq);
    op(A_MSK, 0, 1, 0);
    look(1);
    check("irq", 0, irq);
    op(A_MSK, 32'h1_0000, 1, 0);
    look(1);
    check("irq", 1, irq);
    op(A_EVT, '1, 1, 0);
    op(A_EVT, 0, 0, 0);
    look(1);
    check("irq", 0, irq);
    $display("test irq done");
    end_of_test();
  end
endmodule : igs_group_tb_top
